// ### fsli_blink.sv
// Purpose: constants for the fieldbus status indicator and its blink divider
// Assumes: one 200 MHz clock, synchronous active-low reset
// Notes: the divider toggles its output every HALF cycles of clk_in
`timescale 1ns/1ps
`default_nettype none

package fsli_pkg;
  // system clock
  localparam longint FSLI_CLK_HZ = 200_000_000;
  // blink frequencies in Hz
  localparam longint FSLI_BLINK_SLOW_HZ = 1;
  localparam longint FSLI_BLINK_MID_HZ = 2;
  localparam longint FSLI_BLINK_FAST_HZ = 10;
  // half periods in clock cycles, 50 percent duty
  localparam int FSLI_HALF_SLOW = int'(FSLI_CLK_HZ / (2 * FSLI_BLINK_SLOW_HZ));
  localparam int FSLI_HALF_MID = int'(FSLI_CLK_HZ / (2 * FSLI_BLINK_MID_HZ));
  localparam int FSLI_HALF_FAST = int'(FSLI_CLK_HZ / (2 * FSLI_BLINK_FAST_HZ));
  localparam int FSLI_CNT_W = 27;
  // node condition codes
  localparam int FSLI_NUM_NODES = 8;
  localparam int FSLI_NUM_CAUSE = 11;
  localparam logic [7:0] FSLI_CODE_OK = 8'h00;
  localparam logic [7:0] FSLI_CODE_DEACT = 8'h01;
  localparam logic [7:0] FSLI_CODE_ABSENT = 8'h02;
  localparam logic [7:0] FSLI_CODE_MLOCK = 8'h03;
  localparam logic [7:0] FSLI_CODE_BADRESP = 8'h04;
  localparam logic [7:0] FSLI_CODE_PARAM = 8'h05;
  localparam logic [7:0] FSLI_CODE_UNSUP = 8'h06;
  localparam logic [7:0] FSLI_CODE_CFG = 8'h07;
  localparam logic [7:0] FSLI_CODE_NREADY = 8'h08;
  localparam logic [7:0] FSLI_CODE_SDIAG = 8'h09;
  localparam logic [7:0] FSLI_CODE_DOVF = 8'h0a;
  localparam logic [7:0] FSLI_CODE_PHYS = 8'h0b;
  // slave state machine encodings
  typedef enum logic [3:0] {
    FSLI_ST_INIT = 4'h1,
    FSLI_ST_PREOP = 4'h2,
    FSLI_ST_BOOT = 4'h3,
    FSLI_ST_SAFEOP = 4'h4,
    FSLI_ST_OP = 4'h8
  } fsli_slave_state_t;
endpackage : fsli_pkg

module fsli_blink
  import fsli_pkg::*;
#(
  parameter int HALF = FSLI_HALF_SLOW
) (
  // clock and control
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // square wave
  output logic blink_out
);
  typedef struct packed {
    logic [FSLI_CNT_W-1:0] cnt;
    logic lvl;
  } fsli_blink_st_t;

  localparam logic [FSLI_CNT_W-1:0] LAST = FSLI_CNT_W'(HALF - 1);

  fsli_blink_st_t st_reg;
  fsli_blink_st_t st_next;

  // count half periods and toggle at each wrap
  always_comb begin
    st_next = st_reg;
    if (st_reg.cnt == LAST) begin
      st_next.cnt = '0;
      st_next.lvl = ~st_reg.lvl;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  // state register, frozen while ce_in is low
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign blink_out = st_reg.lvl;
endmodule : fsli_blink

`default_nettype wire

// ### fsli_indicator.sv
// Purpose: status LEDs and per-node condition codes of a CAN gateway
// Assumes: inputs synchronous to clk_in; one clock, synchronous reset
// Notes: LED outputs are active high (1 = lit); the error LED reads the
//   registered codes, so its node-error flashing starts one cycle after
//   the codes; bus-off and restart in one cycle leave the latch set;
//   the HALF_* counts may be shrunk for simulation but must stay >= 1
//
// Operation
// - run LED dark in INIT or BOOTSTRAP
// - run LED flashes 2 Hz in PREOP
// - run LED 1 Hz in SAFEOP, outputs safe
// - run LED steady on in OP
// - error LED dark when all codes zero, host runs
// - error LED 1 Hz if any code nonzero
// - error LED 10 Hz during configuration upload
// - error LED steady at bus-off until restart
// - cpu LED 10 Hz starting, steady on fault
// - 8-bit condition code per configured node
// - code 0 no error, 1 deactivated
// - code 2 absent, 3 master lock
// - code 4 bad response, 5 parameter, 6 unsupported
// - code 7 config, 8 not ready, 9 static diag
// - code 10 diag overflow, 11 physical fault
`timescale 1ns/1ps
`default_nettype none

module fsli_indicator
  import fsli_pkg::*;
#(
  parameter int HALF_SLOW = FSLI_HALF_SLOW,
  parameter int HALF_MID = FSLI_HALF_MID,
  parameter int HALF_FAST = FSLI_HALF_FAST
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // device state
  input wire logic [3:0] slave_state_in,
  input wire logic host_running_in,
  input wire logic cfg_upload_in,
  input wire logic bus_off_in,
  input wire logic restart_in,
  input wire logic cpu_starting_in,
  input wire logic cpu_fault_in,
  // per-node status causes, bit k means code k+1
  input wire logic [FSLI_NUM_NODES-1:0] node_configured_in,
  input wire logic [FSLI_NUM_NODES-1:0][FSLI_NUM_CAUSE-1:0] node_cause_in,
  // indicators
  output logic run_led_out,
  output logic err_led_out,
  output logic cpu_led_out,
  output logic outputs_safe_out,
  // node condition codes
  output logic [FSLI_NUM_NODES-1:0][7:0] node_condition_code_out
);
  typedef struct packed {
    logic bus_off;
    logic run_led;
    logic err_led;
    logic cpu_led;
    logic safe;
    logic [FSLI_NUM_NODES-1:0][7:0] codes;
  } fsli_st_t;

  fsli_st_t st_reg;
  fsli_st_t st_next;

  logic blink_slow;
  logic blink_mid;
  logic blink_fast;
  logic [FSLI_NUM_NODES-1:0][7:0] code_c;
  logic any_err;
  // per-lamp next values, gathered into st_next
  logic bus_off_c;
  logic run_c;
  logic safe_c;
  logic err_c;
  logic cpu_c;

  // divided blink sources, one per documented rate
  fsli_blink #(
    .HALF(HALF_SLOW)
  ) u_blink_slow (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .blink_out(blink_slow)
  );

  fsli_blink #(
    .HALF(HALF_MID)
  ) u_blink_mid (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .blink_out(blink_mid)
  );

  fsli_blink #(
    .HALF(HALF_FAST)
  ) u_blink_fast (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .blink_out(blink_fast)
  );

  // per-node code: lowest active cause wins, unconfigured nodes read 0
  genvar gi;
  generate
    for (gi = 0; gi < FSLI_NUM_NODES; gi++) begin : g_node
      always_comb begin
        code_c[gi] = FSLI_CODE_OK;
        if (node_configured_in[gi]) begin
          for (int k = FSLI_NUM_CAUSE - 1; k >= 0; k--) begin
            if (node_cause_in[gi][k]) begin
              code_c[gi] = 8'(k + 1);
            end
          end
        end
      end
    end
  endgenerate

  // any configured node reporting a non-zero code
  always_comb begin
    any_err = 1'b0;
    for (int n = 0; n < FSLI_NUM_NODES; n++) begin
      if (st_reg.codes[n] != FSLI_CODE_OK) begin
        any_err = 1'b1;
      end
    end
  end

  // bus-off latch: sticky, a new bus-off beats a same-cycle restart
  always_comb begin
    bus_off_c = st_reg.bus_off;
    if (bus_off_in) begin
      bus_off_c = 1'b1;
    end else if (restart_in) begin
      bus_off_c = 1'b0;
    end
  end

  // run LED and output hold from the slave state machine
  always_comb begin
    run_c = 1'b0;
    safe_c = 1'b1;
    case (slave_state_in)
      FSLI_ST_INIT: run_c = 1'b0;
      FSLI_ST_BOOT: run_c = 1'b0;
      FSLI_ST_PREOP: run_c = blink_mid;
      FSLI_ST_SAFEOP: run_c = blink_slow;
      FSLI_ST_OP: begin
        run_c = 1'b1;
        safe_c = 1'b0; // only OP releases the process outputs
      end
      default: run_c = 1'b0; // unknown state: dark, outputs kept safe
    endcase
  end

  // error LED, highest priority first; bus-off is shown from its first cycle
  always_comb begin
    if (st_reg.bus_off || bus_off_in) begin
      err_c = 1'b1;
    end else if (cfg_upload_in) begin
      err_c = blink_fast;
    end else if (any_err) begin
      err_c = blink_slow;
    end else if (host_running_in) begin
      err_c = 1'b0;
    end else begin
      err_c = 1'b0; // host stopped with clean nodes: also kept dark
    end
  end

  // processor LED: fault steady beats start-up flashing
  always_comb begin
    if (cpu_fault_in) begin
      cpu_c = 1'b1;
    end else if (cpu_starting_in) begin
      cpu_c = blink_fast;
    end else begin
      cpu_c = 1'b0;
    end
  end

  // next state: lamps and codes are registered one edge after their inputs; node-error flashing lags the codes by one more edge
  always_comb begin
    st_next = st_reg;
    st_next.codes = code_c;
    st_next.bus_off = bus_off_c;
    st_next.run_led = run_c;
    st_next.safe = safe_c;
    st_next.err_led = err_c;
    st_next.cpu_led = cpu_c;
  end

  // state register, frozen while ce_in is low
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
      st_reg.safe <= 1'b1; // outputs safe until OP is reached
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign run_led_out = st_reg.run_led;
  assign err_led_out = st_reg.err_led;
  assign cpu_led_out = st_reg.cpu_led;
  assign outputs_safe_out = st_reg.safe;
  assign node_condition_code_out = st_reg.codes;
endmodule : fsli_indicator

`default_nettype wire

// ### fsli_indicator_assertions.sv
// Purpose: port checker for fsli_indicator
// Assumes: outputs follow inputs one edge later
// Notes: bound to the design at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module fsli_indicator_chk
  import fsli_pkg::*;
(
  // clock and inputs
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic [3:0] slave_state_in,
  input wire logic bus_off_in,
  input wire logic cpu_fault_in,
  input wire logic [FSLI_NUM_NODES-1:0] node_configured_in,
  input wire logic [FSLI_NUM_NODES-1:0][FSLI_NUM_CAUSE-1:0] node_cause_in,
  // indicators and codes
  input wire logic run_led_out,
  input wire logic err_led_out,
  input wire logic cpu_led_out,
  input wire logic outputs_safe_out,
  input wire logic [FSLI_NUM_NODES-1:0][7:0] node_condition_code_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_dark;
    ce_in && slave_state_in inside {4'h1, 4'h3} |=> !run_led_out;
  endproperty
  a_dark: assert property (p_dark) else $error("run lamp lit");
  property p_safe;
    ce_in && slave_state_in == 4'h4 |=> outputs_safe_out;
  endproperty
  a_safe: assert property (p_safe) else $error("outputs not safe");
  property p_op;
    ce_in && slave_state_in == 4'h8 |=> run_led_out && !outputs_safe_out;
  endproperty
  a_op: assert property (p_op) else $error("run lamp not steady");
  property p_boff;
    ce_in && bus_off_in |=> err_led_out;
  endproperty
  a_boff: assert property (p_boff) else $error("bus off not shown");
  property p_cpu;
    ce_in && cpu_fault_in |=> cpu_led_out;
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu fault not shown");
  property p_deact;
    ce_in && node_configured_in[0] && node_cause_in[0] == 11'h001
      |=> node_condition_code_out[0] == 8'h01;
  endproperty
  a_deact: assert property (p_deact) else $error("code 1 wrong");
  property p_phys;
    ce_in && node_configured_in[0] && node_cause_in[0] == 11'h400
      |=> node_condition_code_out[0] == 8'h0b;
  endproperty
  a_phys: assert property (p_phys) else $error("code 11 wrong");
  property p_unc;
    ce_in && !node_configured_in[1] |=> node_condition_code_out[1] == 8'h00;
  endproperty
  a_unc: assert property (p_unc) else $error("idle node code");
endmodule : fsli_indicator_chk

bind fsli_indicator fsli_indicator_chk chk (.clk_in, .nrst_in, .ce_in,
  .slave_state_in, .bus_off_in, .cpu_fault_in, .node_configured_in,
  .node_cause_in, .run_led_out, .err_led_out, .cpu_led_out,
  .outputs_safe_out, .node_condition_code_out);
`default_nettype wire

// ### fsli_led_watch.sv
// Purpose: lamp model that times the flashing of one indicator
// Assumes: lamp is lit while led_in is high
// Notes: period_out keeps its value while the lamp is steady
`timescale 1ns/1ps
`default_nettype none
module fsli_led_watch (
  // clock and lamp
  input wire logic clk_in,
  input wire logic led_in,
  // cycles between two turn-ons
  output int period_out
);
  int cnt = 0;
  logic led_d = 1'b0;
  // restart the count at each turn-on
  always @(posedge clk_in) begin
    led_d <= led_in;
    cnt <= (led_in && !led_d) ? 1 : cnt + 1;
    if (led_in && !led_d) period_out <= cnt;
  end
endmodule : fsli_led_watch
`default_nettype wire

// ### tb_fieldbus_status_led_indicator.sv
// Purpose: self-checking bench for fsli_indicator
// Assumes: short half periods 10, 5 and 1 cycles
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_fieldbus_status_led_indicator
  import fsli_pkg::*;
;
  localparam int HS = 10;
  localparam int HM = 5;
  localparam int HF = 1;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ce_in = 1'b1;
  logic host_running_in = 1'b1;
  logic [3:0] slave_state_in = 4'h1;
  logic cfg_upload_in = 1'b0;
  logic bus_off_in = 1'b0;
  logic restart_in = 1'b0;
  logic cpu_starting_in = 1'b0;
  logic cpu_fault_in = 1'b0;
  logic [FSLI_NUM_NODES-1:0] node_configured_in = 8'h01;
  logic [FSLI_NUM_NODES-1:0][FSLI_NUM_CAUSE-1:0] node_cause_in = '0;
  logic run_led_out, err_led_out, cpu_led_out, outputs_safe_out;
  logic [FSLI_NUM_NODES-1:0][7:0] node_condition_code_out;
  int run_per, err_per, cpu_per;
  int bad_count = 0;
  int total_checks = 0;
  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;
  fsli_indicator #(.HALF_SLOW(HS), .HALF_MID(HM), .HALF_FAST(HF)) dut (
    .clk_in, .nrst_in, .ce_in, .slave_state_in, .host_running_in,
    .cfg_upload_in, .bus_off_in, .restart_in, .cpu_starting_in,
    .cpu_fault_in, .node_configured_in, .node_cause_in, .run_led_out,
    .err_led_out, .cpu_led_out, .outputs_safe_out, .node_condition_code_out);
  fsli_led_watch w_run (.clk_in, .led_in(run_led_out), .period_out(run_per));
  fsli_led_watch w_err (.clk_in, .led_in(err_led_out), .period_out(err_per));
  fsli_led_watch w_cpu (.clk_in, .led_in(cpu_led_out), .period_out(cpu_per));
  task automatic check(input string name, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc
  task automatic t_run;
    logic [3:0] st [6] = '{4'h1, 4'h3, 4'hf, 4'h2, 4'h4, 4'h8};
    int per [6] = '{0, 0, 0, 2 * HM, 2 * HS, 1};
    for (int i = 0; i < 6; i++) begin
      slave_state_in = st[i];
      cyc(4 * HS);
      if (per[i] > 1) check("run period", run_per, per[i]);
      else check("run level", run_led_out, per[i]);
      check("safe", outputs_safe_out, st[i] != 4'h8);
    end
  endtask : t_run
  task automatic t_codes;
    for (int k = 0; k < FSLI_NUM_CAUSE; k++) begin
      node_cause_in[0] = 11'h001 << k;
      node_cause_in[1] = 11'h001 << k;
      cyc(2);
      check("code", node_condition_code_out[0], k + 1);
      check("idle node", node_condition_code_out[1], 0);
    end
    node_cause_in[0] = 11'h014;
    cyc(2);
    check("lowest code", node_condition_code_out[0], 3);
    cyc(4 * HS);
    check("err slow", err_per, 2 * HS);
    cfg_upload_in = 1'b1;
    cyc(8);
    check("err fast", err_per, 2 * HF);
    bus_off_in = 1'b1;
    cyc(1);
    bus_off_in = 1'b0;
    cyc(10);
    check("bus off", err_led_out, 1);
    cyc(1);
    check("bus off", err_led_out, 1);
    restart_in = 1'b1;
    cyc(1);
    restart_in = 1'b0;
    cfg_upload_in = 1'b0;
    node_cause_in = '0;
    cyc(6);
    check("code ok", node_condition_code_out[0], 0);
    check("err off", err_led_out, 0);
    host_running_in = 1'b0;
    cyc(2);
    check("host stop", err_led_out, 0);
    host_running_in = 1'b1;
  endtask : t_codes
  task automatic t_cpu;
    cpu_starting_in = 1'b1;
    cyc(8);
    check("cpu fast", cpu_per, 2 * HF);
    cpu_fault_in = 1'b1;
    cyc(3);
    check("cpu fault", cpu_led_out, 1);
    cyc(1);
    check("cpu fault", cpu_led_out, 1);
  endtask : t_cpu
  task automatic t_hold;
    logic lvl;
    cpu_fault_in = 1'b0;
    cyc(3);
    lvl = cpu_led_out;
    ce_in = 1'b0;
    slave_state_in = 4'h1;
    cyc(1);
    check("hold cpu", cpu_led_out, lvl);
    cyc(4);
    check("hold cpu", cpu_led_out, lvl);
    check("hold run", run_led_out, 1);
    check("hold safe", outputs_safe_out, 0);
    ce_in = 1'b1;
    cyc(2);
    check("run dark", run_led_out, 0);
    check("safe again", outputs_safe_out, 1);
    cyc(6);
    check("cpu fast", cpu_per, 2 * HF);
  endtask : t_hold
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // reset for 16 cycles, then the scenarios
  initial begin
    cyc(16);
    nrst_in = 1'b1;
    t_run();
    t_codes();
    t_cpu();
    t_hold();
    end_of_test();
  end
endmodule : tb_fieldbus_status_led_indicator
`default_nettype wire
